// *** design/eeprom_pkg.sv ***
// constants, types and state layout for the two-wire eeprom slave
// Operation
// [RULE1] data changes only while clock is low
// [RULE2] falling data, clock high: start condition
// [RULE3] rising data, clock high: stop, standby
// [RULE4] sample on clock rise, drive on fall
// [RULE5] 8-bit words, ack on ninth clock
// [RULE6] standby after power-up and after stop
// [RULE7] controller recovers with nine clocks, start
// [RULE8] device address word follows every start
// [RULE9] upper nibble must match device type
// [RULE10] next three bits match chip-select straps
// [RULE11] lowest address bit selects read or write
// [RULE12] ack on match, else back to standby
// [RULE13] small variant decodes 12-bit word address
// [RULE14] large variant decodes 13-bit word address
// [RULE15] byte write: three acks, then stop; the design acks four bytes: device address, both address bytes and data
// [RULE16] stop after write starts timed program cycle
// [RULE17] page write takes up to 32 bytes
// [RULE18] only low five address bits increment
// [RULE19] controller polls with start and address
// [RULE20] poll acknowledged only after program cycle
// [RULE21] write-protect high blocks all array writes
// [RULE22] data line driven only low, open drain
// [RULE23] protected writes acked but never programmed
// [RULE24] address counter holds last address plus one
// [RULE25] read continues on ack, wraps whole array
package eeprom_pkg;
   localparam int CLK_MHZ = 125;
   localparam int PROG_TIME_US = 5000;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int PROG_CNT_W = 24;
   localparam int ADDR_W = 13;
   localparam int MEM_BYTES = 8192;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_W = 5;
   localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_MASK_SMALL = 13'h0fff;
   localparam logic [ADDR_W-1:0] ADDR_MASK_LARGE = 13'h1fff;
   // apb register map
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] REG_CONFIG = 8'h00;
   localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
   localparam logic [APB_AW-1:0] REG_PEEK_ADDR = 8'h08;
   localparam logic [APB_AW-1:0] REG_PEEK_DATA = 8'h0c;
   localparam int CFG_LARGE_BIT = 0;
   localparam logic CFG_LARGE_RESET = 1'b1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_STANDBY_BIT = 1;
   localparam int STAT_WP_BIT = 2;
   localparam int STAT_ADDR_LSB = 16;
   // pin synchroniser lanes
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_CS_LSB = 2;
   localparam int PIN_WP = 5;
   localparam int PIN_W = 6;

   typedef enum logic [2:0] {
      S_IDLE,
      S_DEV,
      S_ADDR_HI,
      S_ADDR_LO,
      S_WDATA,
      S_RDATA
   } bus_state_type;

   typedef struct packed {
      logic [PIN_W-1:0] sync_m;
      logic [PIN_W-1:0] sync_s;
      logic scl_p;
      logic sda_p;
      bus_state_type state;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic ack_phase;
      logic rd_mode;
      logic master_ack;
      logic sda_drive;
      logic [ADDR_W-1:0] addr;
      logic [PAGE_BYTES-1:0][7:0] page_buf;
      logic [PAGE_BYTES-1:0] page_mask;
      logic busy;
      logic [PROG_CNT_W-1:0] prog_cnt;
      logic cfg_large;
      logic [ADDR_W-1:0] peek_addr;
      logic [31:0] prdata;
      logic pslverr;
   } slave_state_type;
endpackage : eeprom_pkg

// *** design/eeprom_array.sv ***
// byte array of the eeprom with one write and two read ports
`timescale 1ns/10ps
module eeprom_array
   import eeprom_pkg::*;
(
   input wire logic pclk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr_a,
   output logic [7:0] rd_data_a,
   input wire logic [ADDR_W-1:0] rd_addr_b,
   output logic [7:0] rd_data_b
);
   logic [7:0] mem [MEM_BYTES];

   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign rd_data_a = mem[rd_addr_a];
   assign rd_data_b = mem[rd_addr_b];
endmodule : eeprom_array

// *** design/serial_eeprom_bus_slave.sv ***
// two-wire eeprom target with apb status and configuration registers
`timescale 1ns/10ps
module serial_eeprom_bus_slave
   import eeprom_pkg::*;
#(
   parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [2:0] chip_select_straps,
   input wire logic write_protect
);
   slave_state_type r;
   slave_state_type n;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [2:0] straps_s;
   logic wp_s;
   logic [ADDR_W-1:0] addr_mask;
   logic [ADDR_W-1:0] addr_inc;
   logic dev_match;
   logic commit_en;
   logic [ADDR_W-1:0] commit_addr;
   logic [7:0] rd_data_a;
   logic [7:0] rd_data_b;

   ////////////////////////////////////////////////////////////////////////////
   // bus condition decode on synchronised pins

   assign scl_s = r.sync_s[PIN_SCL];
   assign sda_s = r.sync_s[PIN_SDA];
   assign straps_s = r.sync_s[PIN_CS_LSB +: 3];
   assign wp_s = r.sync_s[PIN_WP];
   assign scl_rise = scl_s & ~r.scl_p;
   assign scl_fall = ~scl_s & r.scl_p;
   assign start_det = scl_s & r.scl_p & r.sda_p & ~sda_s; // see [RULE2] [RULE1]
   assign stop_det = scl_s & r.scl_p & ~r.sda_p & sda_s; // see [RULE3] [RULE1]
   assign addr_mask = r.cfg_large ? ADDR_MASK_LARGE : ADDR_MASK_SMALL; // see [RULE13] [RULE14]
   assign addr_inc = (r.addr + 13'h1) & addr_mask; // see [RULE25]
   assign dev_match = (r.shreg[7:4] == DEV_TYPE_CODE) // see [RULE9]
      && (r.shreg[3:1] == straps_s) // see [RULE10]
      && !r.busy; // see [RULE20]

   // page buffer drains into the array during the first cycles of programming
   assign commit_en = r.busy && (r.prog_cnt < PROG_CNT_W'(PAGE_BYTES))
      && r.page_mask[r.prog_cnt[PAGE_W-1:0]];
   assign commit_addr = {r.addr[ADDR_W-1:PAGE_W], r.prog_cnt[PAGE_W-1:0]};

   eeprom_array u_array (
      .pclk(pclk),
      .wr_en(commit_en),
      .wr_addr(commit_addr),
      .wr_data(r.page_buf[r.prog_cnt[PAGE_W-1:0]]),
      .rd_addr_a(r.addr),
      .rd_data_a(rd_data_a),
      .rd_addr_b(r.peek_addr),
      .rd_data_b(rd_data_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      n = r;
      n.sync_m = {write_protect, chip_select_straps, sda_i, scl};
      n.sync_s = r.sync_m;
      n.scl_p = scl_s;
      n.sda_p = sda_s;

      // self-timed programming
      if (r.busy) begin
         n.prog_cnt = r.prog_cnt + PROG_CNT_W'(1);
         if (r.prog_cnt == PROG_CNT_W'(PROG_CYCLES_P - 1)) begin // see [RULE16]
            n.busy = 1'b0;
            n.page_mask = '0;
         end
      end

      if (stop_det) begin
         n.state = S_IDLE; // see [RULE3] [RULE6]
         n.sda_drive = 1'b0;
         n.ack_phase = 1'b0;
         n.bitcnt = '0;
         if (!r.busy) begin
            n.page_mask = '0;
            if ((|r.page_mask) && !wp_s) begin // see [RULE16] [RULE21] [RULE23]
               n.busy = 1'b1;
               n.prog_cnt = '0;
               n.page_mask = r.page_mask;
            end
         end
      end else if (start_det) begin
         n.state = S_DEV; // see [RULE8]
         n.sda_drive = 1'b0;
         n.ack_phase = 1'b0;
         n.bitcnt = '0;
         if (!r.busy) begin
            n.page_mask = '0;
         end
      end else if (r.state == S_RDATA) begin
         if (scl_rise) begin
            if (r.ack_phase) begin
               n.master_ack = ~sda_s; // see [RULE4]
               n.addr = addr_inc; // see [RULE24] [RULE25]
            end else begin
               n.bitcnt = r.bitcnt + 4'h1;
            end
         end else if (scl_fall) begin
            if (r.ack_phase) begin
               n.ack_phase = 1'b0;
               n.bitcnt = '0;
               if (r.master_ack) begin
                  n.shreg = rd_data_a; // see [RULE25]
                  n.sda_drive = ~rd_data_a[7]; // see [RULE22]
               end else begin
                  n.state = S_IDLE;
                  n.sda_drive = 1'b0;
               end
            end else if (r.bitcnt == BITS_PER_WORD) begin
               n.sda_drive = 1'b0; // see [RULE5]
               n.ack_phase = 1'b1;
            end else begin
               n.shreg = {r.shreg[6:0], 1'b0};
               n.sda_drive = ~r.shreg[6]; // see [RULE4] [RULE22]
            end
         end
      end else if (r.state != S_IDLE) begin
         if (scl_rise && !r.ack_phase) begin
            n.shreg = {r.shreg[6:0], sda_s}; // see [RULE4]
            n.bitcnt = r.bitcnt + 4'h1;
         end else if (scl_fall && r.ack_phase) begin
            n.ack_phase = 1'b0;
            n.sda_drive = 1'b0;
            n.bitcnt = '0;
            unique case (r.state)
               S_DEV: begin
                  if (r.rd_mode) begin
                     n.state = S_RDATA; // see [RULE24]
                     n.shreg = rd_data_a;
                     n.sda_drive = ~rd_data_a[7];
                  end else begin
                     n.state = S_ADDR_HI;
                  end
               end
               S_ADDR_HI: n.state = S_ADDR_LO;
               S_ADDR_LO: n.state = S_WDATA;
               S_WDATA: n.state = S_WDATA; // see [RULE17]
               default: n.state = S_IDLE;
            endcase
         end else if (scl_fall && r.bitcnt == BITS_PER_WORD) begin
            n.ack_phase = 1'b1;
            n.sda_drive = 1'b1; // see [RULE5] [RULE15]
            unique case (r.state)
               S_DEV: begin
                  n.rd_mode = r.shreg[0]; // see [RULE11]
                  if (!dev_match) begin
                     n.state = S_IDLE; // see [RULE12]
                     n.ack_phase = 1'b0;
                     n.sda_drive = 1'b0;
                     n.bitcnt = '0;
                  end
               end
               S_ADDR_HI: begin
                  n.addr[ADDR_W-1:8] = r.shreg[ADDR_W-9:0];
               end
               S_ADDR_LO: begin
                  n.addr = {r.addr[ADDR_W-1:8], r.shreg} & addr_mask; // see [RULE13] [RULE14]
               end
               S_WDATA: begin
                  n.page_buf[r.addr[PAGE_W-1:0]] = r.shreg;
                  n.page_mask[r.addr[PAGE_W-1:0]] = 1'b1;
                  n.addr[PAGE_W-1:0] = r.addr[PAGE_W-1:0] + 5'h1; // see [RULE18]
               end
               default: n.state = S_IDLE;
            endcase
         end
      end

      // apb slave: read data set up in the setup cycle, writes in access
      if (psel && !penable) begin
         n.pslverr = 1'b0;
         n.prdata = '0;
         unique case (paddr)
            REG_CONFIG: n.prdata[CFG_LARGE_BIT] = r.cfg_large;
            REG_STATUS: begin
               n.prdata[STAT_BUSY_BIT] = r.busy;
               n.prdata[STAT_STANDBY_BIT] = (r.state == S_IDLE) && !r.busy; // see [RULE6]
               n.prdata[STAT_WP_BIT] = wp_s;
               n.prdata[STAT_ADDR_LSB +: ADDR_W] = r.addr;
            end
            REG_PEEK_ADDR: n.prdata[ADDR_W-1:0] = r.peek_addr;
            REG_PEEK_DATA: n.prdata[7:0] = rd_data_b;
            default: n.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && pwrite) begin
         if (paddr == REG_CONFIG) begin
            n.cfg_large = pwdata[CFG_LARGE_BIT];
         end
         if (paddr == REG_PEEK_ADDR) begin
            n.peek_addr = pwdata[ADDR_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.sync_m <= '1;
         r.sync_s <= '1;
         r.scl_p <= 1'b1;
         r.sda_p <= 1'b1;
         r.state <= S_IDLE; // see [RULE6]
         r.cfg_large <= CFG_LARGE_RESET;
      end else begin
         r <= n;
      end
   end

   assign sda_o = 1'b0; // see [RULE22]
   assign sda_oe = r.sda_drive;
   assign prdata = r.prdata;
   assign pslverr = r.pslverr & psel & penable;
   assign pready = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_open_drain;
      @(posedge pclk) disable iff (!presetn)
      sda_oe |-> (sda_o == 1'b0);
   endproperty
   a_open_drain: assert property (p_open_drain) // see [RULE22]
      else $error("data line driven high");

   property p_drive_on_fall;
      @(posedge pclk) disable iff (!presetn)
      $changed(r.sda_drive) |-> $past(scl_fall || start_det || stop_det);
   endproperty
   a_drive_on_fall: assert property (p_drive_on_fall) // see [RULE4]
      else $error("data output changed outside clock fall");

   property p_ack_after_word;
      @(posedge pclk) disable iff (!presetn)
      $rose(r.ack_phase) |-> ($past(r.bitcnt) == BITS_PER_WORD) && $past(scl_fall);
   endproperty
   a_ack_after_word: assert property (p_ack_after_word) // see [RULE5]
      else $error("ack slot opened before eight bits");

   property p_match_only;
      @(posedge pclk) disable iff (!presetn)
      (r.state == S_DEV && r.ack_phase && r.sda_drive) |->
         (r.shreg[7:4] == DEV_TYPE_CODE) && (r.shreg[3:1] == straps_s);
   endproperty
   a_match_only: assert property (p_match_only) // see [RULE12]
      else $error("device address acked without match");

   property p_no_ack_busy;
      @(posedge pclk) disable iff (!presetn)
      r.busy |-> !(r.state == S_DEV && r.ack_phase);
   endproperty
   a_no_ack_busy: assert property (p_no_ack_busy) // see [RULE20]
      else $error("poll acked during program cycle");

   property p_start_to_dev;
      @(posedge pclk) disable iff (!presetn)
      (start_det && !stop_det) |=> (r.state == S_DEV) && (r.bitcnt == 4'h0) && !r.sda_drive;
   endproperty
   a_start_to_dev: assert property (p_start_to_dev) // see [RULE2]
      else $error("start did not restart address phase");

   property p_stop_idle;
      @(posedge pclk) disable iff (!presetn)
      stop_det |=> (r.state == S_IDLE) && !r.sda_drive;
   endproperty
   a_stop_idle: assert property (p_stop_idle) // see [RULE3]
      else $error("stop did not return to standby");

   property p_wp_blocks;
      @(posedge pclk) disable iff (!presetn)
      (stop_det && wp_s && !r.busy) |=> !r.busy && (r.page_mask == '0);
   endproperty
   a_wp_blocks: assert property (p_wp_blocks) // see [RULE21]
      else $error("protected write started programming");

   property p_prog_start;
      @(posedge pclk) disable iff (!presetn)
      $rose(r.busy) |-> ($past(stop_det) && (r.prog_cnt == '0)) ##1 r.busy[*8];
   endproperty
   a_prog_start: assert property (p_prog_start) // see [RULE16]
      else $error("program cycle not started by stop");

   property p_prog_end;
      @(posedge pclk) disable iff (!presetn)
      (r.busy && r.prog_cnt == PROG_CNT_W'(PROG_CYCLES_P - 1)) |=> !r.busy;
   endproperty
   a_prog_end: assert property (p_prog_end) // see [RULE16]
      else $error("program cycle length wrong");

   property p_page_wrap;
      @(posedge pclk) disable iff (!presetn)
      (r.state == S_WDATA && scl_fall && !r.ack_phase && r.bitcnt == BITS_PER_WORD
         && !start_det && !stop_det)
      |=> (r.addr[ADDR_W-1:PAGE_W] == $past(r.addr[ADDR_W-1:PAGE_W]))
         && (r.addr[PAGE_W-1:0] == 5'($past(r.addr[PAGE_W-1:0]) + 5'h1));
   endproperty
   a_page_wrap: assert property (p_page_wrap) // see [RULE18]
      else $error("write address left its page");

   property p_busy_quiet;
      @(posedge pclk) disable iff (!presetn)
      r.busy |-> !r.sda_drive;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) // see [RULE16]
      else $error("data line pulled during program cycle");

   property p_prog_hold;
      @(posedge pclk) disable iff (!presetn)
      (r.busy && $past(r.busy)) |-> (r.addr == $past(r.addr));
   endproperty
   a_prog_hold: assert property (p_prog_hold) // see [RULE16]
      else $error("word address moved during program cycle");

   property p_host_ack_slot;
      @(posedge pclk) disable iff (!presetn)
      (r.state == S_RDATA && r.ack_phase) |-> !r.sda_drive;
   endproperty
   a_host_ack_slot: assert property (p_host_ack_slot) // see [RULE25]
      else $error("data line held in controller ack slot");
endmodule : serial_eeprom_bus_slave

// *** verif/link_ctrl.sv ***
// two-wire bus controller model driving the link clock and sharing data
`timescale 1ns/10ps
module link_ctrl (
   input wire logic pclk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic half();
      repeat (10) @(posedge pclk);
   endtask : half
   // one clock, data set while low
   task automatic bit_io(input logic b, output logic s);
      sda_low <= ~b;
      half();
      scl <= 1'b1;
      half();
      s = sda;
      scl <= 1'b0;
   endtask : bit_io
   task automatic start();
      sda_low <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_low <= 1'b1;
      half();
      scl <= 1'b0;
   endtask : start
   // leaves clock high and data released
   task automatic stop();
      sda_low <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_low <= 1'b0;
      half();
   endtask : stop
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask : send
   task automatic recv(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~ack, s);
   endtask : recv
   task automatic recover();
      logic s;
      repeat (9) bit_io(1'b1, s);
      start();
      stop();
   endtask : recover
endmodule : link_ctrl

// *** verif/serial_eeprom_bus_slave_tb.sv ***
// self-checking bench for the two-wire eeprom target
`timescale 1ns/10ps
module serial_eeprom_bus_slave_tb
   import eeprom_pkg::*;
;
   typedef struct packed {
      logic [ADDR_W-1:0] a;
      logic [5:0] n;
      logic [7:0] d0;
   } row_type;
   localparam row_type ROWS [4] = '{'{13'h0000, 6'd1, 8'h33}, '{13'h0105, 6'd4, 8'h20},
      '{13'h1fe0, 6'd32, 8'h40}, '{13'h023e, 6'd34, 8'h80}};
   localparam int LIMIT = 60000;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, q;
   logic pready, pslverr, sda_o, sda_oe, scl, sda_low, sda, e;
   logic [2:0] straps = 3'h5;
   logic write_protect = 1'b0;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   assign sda = ~(sda_oe & ~sda_o) & ~sda_low;
   always #4 pclk = ~pclk;
   serial_eeprom_bus_slave #(.PROG_CYCLES_P(400)) serial_eeprom_bus_slave_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .chip_select_straps(straps), .write_protect(write_protect));
   link_ctrl link_ctrl_i (.pclk(pclk), .sda(sda), .scl(scl), .sda_low(sda_low));
   ////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] s, input logic [31:0] x, input string w);
      check_count++;
      if (s !== x) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", w, x, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic peek(input logic [ADDR_W-1:0] a, output logic [7:0] v);
      apb(1'b1, REG_PEEK_ADDR, 32'(a));
      apb(1'b0, REG_PEEK_DATA, 32'h0);
      v = q[7:0];
   endtask : peek
   task automatic addr_phase(input logic [ADDR_W-1:0] a, output logic ok);
      logic k1, k2, k3;
      link_ctrl_i.start();
      link_ctrl_i.send({4'ha, straps, 1'b0}, k1);
      link_ctrl_i.send({3'h0, a[12:8]}, k2);
      link_ctrl_i.send(a[7:0], k3);
      ok = k1 & k2 & k3;
   endtask : addr_phase
   task automatic wr(input row_type r, output logic ok);
      logic k;
      addr_phase(r.a, ok);
      for (int i = 0; i < r.n; i++) begin
         link_ctrl_i.send(r.d0 + 8'(i), k);
         ok &= k;
      end
      link_ctrl_i.stop();
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input int n, output logic [15:0] d);
      logic ok, k;
      addr_phase(a, ok);
      link_ctrl_i.start();
      link_ctrl_i.send({4'ha, straps, 1'b1}, k);
      for (int i = 0; i < n; i++) link_ctrl_i.recv(i < n - 1, d[15-8*i -: 8]);
      link_ctrl_i.stop();
      chk(32'({ok, k}), 32'h3, "read acks");
   endtask : rd
   task automatic poll(output int tries);
      logic k;
      tries = 0;
      do begin
         link_ctrl_i.start();
         link_ctrl_i.send({4'ha, straps, 1'b0}, k);
         tries++;
      end while (k !== 1'b1 && tries < 20);
      link_ctrl_i.stop();
   endtask : poll
   ////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (sda_oe === 1'b1) chk(32'(sda_o), 32'h0, "sda_o");
      if (cyc == LIMIT) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      logic ok;
      logic [7:0] v;
      logic [15:0] d;
      logic [ADDR_W-1:0] s;
      int t;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_CONFIG, 32'h0);
      chk(q, 32'h1, "config reset");
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(q[1:0]), 32'h2, "status reset");
      apb(1'b0, 8'h10, 32'h0);
      chk(32'(e), 32'h1, "unmapped");
      link_ctrl_i.recover();
      foreach (ROWS[j]) begin
         wr(ROWS[j], ok);
         chk(32'(ok), 32'h1, "write acks");
         apb(1'b0, REG_STATUS, 32'h0);
         chk(32'(q[0]), 32'h1, "busy");
         s = {ROWS[j].a[12:5], ROWS[j].a[4:0] + ROWS[j].n[4:0]};
         chk(32'(q[28:16]), 32'(s), "counter");
         poll(t);
         chk(32'(t > 1), 32'h1, "poll refused");
         for (int k = 0; k < ROWS[j].n && k < 32; k++) begin
            peek({ROWS[j].a[12:5], 5'(ROWS[j].a[4:0] + k)}, v);
            chk(32'(v), 32'(8'(ROWS[j].d0 + k + (k + 32 < ROWS[j].n ? 32 : 0))), "array");
         end
         t = ROWS[j].n > 1 ? 2 : 1;
         rd(ROWS[j].a, t, d);
         chk(32'(d[15:8]), 32'(8'(ROWS[j].d0 + (ROWS[j].n > 32 ? 32 : 0))), "read");
         if (t > 1) chk(32'(d[7:0]), 32'(8'(ROWS[j].d0 + (ROWS[j].n > 33 ? 33 : 1))), "seq");
         $display("row %0d done", j);
      end
      rd(13'h1fff, 2, d);
      chk(32'(d), 32'h5f33, "array wrap");
      apb(1'b1, REG_CONFIG, 32'h0);
      // last byte of the small space must be known before reading across it
      wr(row_type'{13'h0fff, 6'd1, 8'h77}, ok);
      chk(32'(ok), 32'h1, "small write acks");
      poll(t);
      rd(13'h0fff, 2, d);
      chk(32'(d), 32'h7733, "small read wrap");
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(q[28:16]), 32'h1, "small wrap");
      apb(1'b1, REG_CONFIG, 32'h1);
      $display("wrap test done");
      for (int m = 0; m < 2; m++) begin
         link_ctrl_i.start();
         link_ctrl_i.send(m ? {4'ha, ~straps, 1'b0} : {4'hb, straps, 1'b0}, ok);
         link_ctrl_i.stop();
         chk(32'(ok), 32'h0, "foreign address");
      end
      $display("address test done");
      write_protect <= 1'b1;
      wr(row_type'{13'h0000, 6'd1, 8'hee}, ok);
      chk(32'(ok), 32'h1, "protected acks");
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(q[2:0]), 32'h6, "protected status");
      peek(13'h0000, v);
      chk(32'(v), 32'h33, "protected array");
      write_protect <= 1'b0;
      $display("protect test done");
      // mid-run reset with a non-default configuration
      apb(1'b1, REG_CONFIG, 32'h0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_CONFIG, 32'h0);
      chk(q, 32'h1, "config after reset");
      apb(1'b0, REG_STATUS, 32'h0);
      chk(q, 32'h2, "status after reset");
      $display("reset test done");
      print_verdict();
   end
endmodule : serial_eeprom_bus_slave_tb
